/* File: hdl/mscr_pkg.sv */
// Package of constants for the metering configuration register bank
package mscr_pkg;
  // ==========================================================================
  // Special-function register addresses
  localparam logic [7:0]  SFR_PORT0_DATA  = 8'h80;
  localparam logic [7:0]  SFR_PORT1_DATA  = 8'h90;
  localparam logic [7:0]  SFR_PORT1_DIR   = 8'h91;
  localparam logic [7:0]  SFR_FLASH_ERASE = 8'h94;
  localparam logic [7:0]  SFR_EE_DATA     = 8'h9e;
  localparam logic [7:0]  SFR_EE_CTRL     = 8'h9f;
  localparam logic [7:0]  SFR_PORT2_DATA  = 8'ha0;
  localparam logic [7:0]  SFR_PORT2_DIR   = 8'ha1;
  localparam logic [7:0]  SFR_PORT0_DIR   = 8'ha2;
  localparam logic [7:0]  SFR_FLASH_CTRL  = 8'hb2;
  localparam logic [7:0]  SFR_FLASH_PAGE  = 8'hb7;
  localparam logic [7:0]  SFR_INT_FLAGS   = 8'he8;
  localparam logic [7:0]  SFR_INT_BITS    = 8'hf8;
  // ==========================================================================
  // External window addresses
  localparam logic [15:0] XA_ENGINE0  = 16'h2000;
  localparam logic [15:0] XA_ENGINE2  = 16'h2002;
  localparam logic [15:0] XA_COMP     = 16'h2003;
  localparam logic [15:0] XA_CONFIG0  = 16'h2004;
  localparam logic [15:0] XA_CONFIG1  = 16'h2005;
  localparam logic [15:0] XA_LCDX     = 16'h2020;
  localparam logic [15:0] XA_ENGINE3  = 16'h20a8;
  // ==========================================================================
  // Storage masks: a zero bit has no flip-flop and reads zero
  localparam logic [7:0]  MASK_PORT0     = 8'hf7;
  localparam logic [7:0]  MASK_PORT0_DIR = 8'hf6;
  localparam logic [7:0]  MASK_PORT1     = 8'hcf;
  localparam logic [7:0]  MASK_PORT2_L   = 8'h03;
  localparam logic [7:0]  MASK_PORT2_Q   = 8'h38;
  localparam logic [7:0]  MASK_FLASH_CTL = 8'h03;
  localparam logic [7:0]  MASK_FLASH_PG  = 8'hfe;
  localparam logic [7:0]  MASK_ENGINE0   = 8'h10;
  localparam logic [7:0]  MASK_ENGINE2   = 8'h30;
  localparam logic [7:0]  MASK_CONFIG0   = 8'h30;
  localparam logic [7:0]  MASK_CONFIG1   = 8'h08;
  localparam logic [7:0]  MASK_LCDX      = 8'h40;
  localparam logic [7:0]  MASK_ENGINE3   = 8'h1f;
  // ==========================================================================
  // Field positions
  localparam int          BIT_ENGINE_EN  = 4;
  localparam int          BIT_CONV_EN    = 3;
  localparam int          BIT_BATT       = 6;
  localparam int          BIT_COMP       = 0;
  localparam int          LSB_CHOP       = 4;
  localparam int          LSB_CKOUT      = 4;
  localparam int          LOC_W          = 5;
  localparam logic [4:0]  LOC_RESET      = 5'h1f;
  localparam int          LOC_SHIFT      = 10;
  // ==========================================================================
  // Modes
  typedef enum logic [1:0] {
    CHOP_AUTO = 2'h0, CHOP_POS = 2'h1, CHOP_REV = 2'h2, CHOP_TOG = 2'h3
  } mscr_chop_t;
  typedef enum logic [1:0] {
    CK_LCD_SEGMENT_19 = 2'h0, CK_FILTER = 2'h1, CK_RSV2 = 2'h2, CK_RSV3 = 2'h3
  } mscr_ckout_t;
endpackage

/* File: hdl/mscr_sync.sv */
// Two-flop synchroniser for pin-side levels
`timescale 1ns/1ns
`default_nettype none
module mscr_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_resetn,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
    end
    else
    begin
      s1_reg <= i_d;
      s2_reg <= s1_reg;
    end
  end
  assign o_q = s2_reg;
endmodule
`default_nettype wire

/* File: hdl/mscr_chop.sv */
// Bandgap chop state machine stepped by the mux sync pulse
`timescale 1ns/1ns
`default_nettype none
module mscr_chop (
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_sync,
  input  wire logic       i_acc_end,
  input  wire logic [1:0] i_mode,
  output logic            o_chop
);
  logic sync_d_reg;
  logic chop_reg;
  logic chop_next;
  logic rise;
  assign rise = i_sync & ~sync_d_reg;
  always_comb
  begin
    chop_next = chop_reg;
    if (rise)
    begin
      case (mscr_pkg::mscr_chop_t'(i_mode))
        mscr_pkg::CHOP_POS:  chop_next = 1'b0;
        mscr_pkg::CHOP_REV:  chop_next = 1'b1;
        mscr_pkg::CHOP_TOG:  chop_next = ~chop_reg;
        mscr_pkg::CHOP_AUTO: chop_next = i_acc_end ? chop_reg : ~chop_reg;
        default:             chop_next = chop_reg;
      endcase
    end
  end
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      sync_d_reg <= 1'b0;
      chop_reg   <= 1'b0;
    end
    else
    begin
      sync_d_reg <= i_sync;
      chop_reg   <= chop_next;
    end
  end
  assign o_chop = chop_reg;
  property p_chop_pos;
    @(posedge i_clk) disable iff (!i_resetn)
    (rise && i_mode == 2'h1) |=> !o_chop;
  endproperty
  a_chop_pos: assert property (p_chop_pos) else $error("chop not positive");
  property p_chop_rev;
    @(posedge i_clk) disable iff (!i_resetn)
    (rise && i_mode == 2'h2) |=> o_chop;
  endproperty
  a_chop_rev: assert property (p_chop_rev) else $error("chop not reversed");
  property p_chop_tog;
    @(posedge i_clk) disable iff (!i_resetn)
    (rise && i_mode == 2'h3) |=> (o_chop != $past(o_chop));
  endproperty
  a_chop_tog: assert property (p_chop_tog) else $error("chop not toggled");
  property p_chop_hold;
    @(posedge i_clk) disable iff (!i_resetn)
    (rise && i_mode == 2'h0 && i_acc_end) |=> $stable(o_chop);
  endproperty
  a_chop_hold: assert property (p_chop_hold) else $error("chop moved at end");
endmodule
`default_nettype wire

/* File: hdl/mscr_top.sv */
// Configuration and status register bank of the metering chip
`timescale 1ns/1ns
`default_nettype none
module mscr_top #(
  parameter bit LARGE_PKG = 1'b1
) (
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic [7:0]  i_sfr_addr,
  input  wire logic        i_sfr_wr,
  input  wire logic        i_sfr_rd,
  input  wire logic [7:0]  i_sfr_wdata,
  output logic      [7:0]  o_sfr_rdata,
  input  wire logic [15:0] i_xa_addr,
  input  wire logic        i_xa_wr,
  input  wire logic        i_xa_rd,
  input  wire logic [7:0]  i_xa_wdata,
  output logic      [7:0]  o_xa_rdata,
  input  wire logic [7:0]  i_int_set,
  input  wire logic [6:0]  i_int_bits,
  input  wire logic        i_comp_pin,
  input  wire logic        i_mux_sync,
  input  wire logic        i_acc_end,
  input  wire logic [7:0]  i_gpio_sel,
  input  wire logic [7:0]  i_p0_pin,
  input  wire logic [7:0]  i_p1_pin,
  input  wire logic [7:0]  i_p2_pin,
  output logic      [7:0]  o_p0_out,
  output logic      [7:0]  o_p0_oe,
  output logic      [7:0]  o_p1_out,
  output logic      [7:0]  o_p1_oe,
  output logic      [7:0]  o_p2_out,
  output logic      [7:0]  o_p2_oe,
  output logic             o_conv_enable,
  output logic             o_conv_bias_on,
  output logic             o_engine_enable,
  output logic      [14:0] o_engine_start,
  output logic             o_batt_load,
  output logic             o_batt_to_conv,
  output logic             o_chop,
  output logic      [1:0]  o_test_clock_out_select,
  output logic             o_test_clk_is_filter,
  output logic             o_test_clk_is_lcd_segment_19,
  output logic      [7:0]  o_flash_erase,
  output logic      [7:0]  o_flash_ctrl,
  output logic      [7:0]  o_flash_page,
  output logic      [7:0]  o_eeprom_data,
  output logic      [7:0]  o_eeprom_ctrl
);
  // ==========================================================================
  // Package-dependent mask for port 2
  localparam logic [7:0] MASK_P2 = LARGE_PKG ? (mscr_pkg::MASK_PORT2_L | mscr_pkg::MASK_PORT2_Q)
                                             : mscr_pkg::MASK_PORT2_L;
  // ==========================================================================
  // Pin synchronisers
  logic        comp_s;
  logic [23:0] pins_s;
  logic [23:0] pins_raw;
  assign pins_raw = {i_p2_pin, i_p1_pin, i_p0_pin};
  mscr_sync #(.W(1)) u_sync_comp (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_d      (i_comp_pin),
    .o_q      (comp_s)
  );
  mscr_sync #(.W(24)) u_sync_pins (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_d      (pins_raw),
    .o_q      (pins_s)
  );
  // ==========================================================================
  // Register state
  logic [7:0] p0_reg, p0_next, p0d_reg, p0d_next;
  logic [7:0] p1_reg, p1_next, p1d_reg, p1d_next;
  logic [7:0] p2_reg, p2_next, p2d_reg, p2d_next;
  logic [7:0] er_reg, er_next, eed_reg, eed_next, eec_reg, eec_next;
  logic [7:0] fc_reg, fc_next, fp_reg, fp_next, if_reg, if_next;
  logic [7:0] e0_reg, e0_next, e2_reg, e2_next, c0_reg, c0_next;
  logic [7:0] c1_reg, c1_next, lx_reg, lx_next, e3_reg, e3_next;
  logic [7:0] srd_next, xrd_next;
  logic [7:0] srd_reg, xrd_reg;
  logic       ck19_reg, ck19_next, ckfir_reg, ckfir_next;
  // Only stored bits take the write; others stay zero
  function automatic logic [7:0] wr_bits(input logic [7:0] cur, input logic [7:0] d, input logic [7:0] m);
    wr_bits = (d & m) | (cur & ~m);
  endfunction
  function automatic logic sfr_hit(input logic [7:0] a, input logic [7:0] r, input logic w);
    sfr_hit = w && (a == r);
  endfunction
  always_comb
  begin
    p0_next = p0_reg; p0d_next = p0d_reg; p1_next = p1_reg; p1d_next = p1d_reg;
    p2_next = p2_reg; p2d_next = p2d_reg; er_next = er_reg; eed_next = eed_reg;
    eec_next = eec_reg; fc_next = fc_reg; fp_next = fp_reg;
    e0_next = e0_reg; e2_next = e2_reg; c0_next = c0_reg; c1_next = c1_reg;
    lx_next = lx_reg; e3_next = e3_reg;
    // Hardware sets win over a software clear in the same cycle
    if_next = if_reg;
    if (sfr_hit(i_sfr_addr, mscr_pkg::SFR_INT_FLAGS, i_sfr_wr))
      if_next = i_sfr_wdata;
    if_next = if_next | i_int_set;
    // SFR space writes, effective on this edge
    if (sfr_hit(i_sfr_addr, mscr_pkg::SFR_PORT0_DATA, i_sfr_wr))  p0_next  = wr_bits(p0_reg, i_sfr_wdata, mscr_pkg::MASK_PORT0);
    if (sfr_hit(i_sfr_addr, mscr_pkg::SFR_PORT0_DIR, i_sfr_wr))   p0d_next = wr_bits(p0d_reg, i_sfr_wdata, mscr_pkg::MASK_PORT0_DIR);
    if (sfr_hit(i_sfr_addr, mscr_pkg::SFR_PORT1_DATA, i_sfr_wr))  p1_next  = wr_bits(p1_reg, i_sfr_wdata, mscr_pkg::MASK_PORT1);
    if (sfr_hit(i_sfr_addr, mscr_pkg::SFR_PORT1_DIR, i_sfr_wr))   p1d_next = wr_bits(p1d_reg, i_sfr_wdata, mscr_pkg::MASK_PORT1);
    if (sfr_hit(i_sfr_addr, mscr_pkg::SFR_PORT2_DATA, i_sfr_wr))  p2_next  = wr_bits(p2_reg, i_sfr_wdata, MASK_P2);
    if (sfr_hit(i_sfr_addr, mscr_pkg::SFR_PORT2_DIR, i_sfr_wr))   p2d_next = wr_bits(p2d_reg, i_sfr_wdata, MASK_P2);
    if (sfr_hit(i_sfr_addr, mscr_pkg::SFR_FLASH_ERASE, i_sfr_wr)) er_next  = i_sfr_wdata;
    if (sfr_hit(i_sfr_addr, mscr_pkg::SFR_EE_DATA, i_sfr_wr))     eed_next = i_sfr_wdata;
    if (sfr_hit(i_sfr_addr, mscr_pkg::SFR_EE_CTRL, i_sfr_wr))     eec_next = i_sfr_wdata;
    if (sfr_hit(i_sfr_addr, mscr_pkg::SFR_FLASH_CTRL, i_sfr_wr))  fc_next  = wr_bits(fc_reg, i_sfr_wdata, mscr_pkg::MASK_FLASH_CTL);
    if (sfr_hit(i_sfr_addr, mscr_pkg::SFR_FLASH_PAGE, i_sfr_wr))  fp_next  = wr_bits(fp_reg, i_sfr_wdata, mscr_pkg::MASK_FLASH_PG);
    // External window writes
    if (i_xa_wr)
    begin
      case (i_xa_addr)
        mscr_pkg::XA_ENGINE0: e0_next = wr_bits(e0_reg, i_xa_wdata, mscr_pkg::MASK_ENGINE0);
        mscr_pkg::XA_ENGINE2: e2_next = wr_bits(e2_reg, i_xa_wdata, mscr_pkg::MASK_ENGINE2);
        mscr_pkg::XA_CONFIG0: c0_next = wr_bits(c0_reg, i_xa_wdata, mscr_pkg::MASK_CONFIG0);
        mscr_pkg::XA_CONFIG1: c1_next = wr_bits(c1_reg, i_xa_wdata, mscr_pkg::MASK_CONFIG1);
        mscr_pkg::XA_LCDX:    lx_next = wr_bits(lx_reg, i_xa_wdata, mscr_pkg::MASK_LCDX);
        mscr_pkg::XA_ENGINE3: e3_next = wr_bits(e3_reg, i_xa_wdata, mscr_pkg::MASK_ENGINE3);
        default:              e0_next = e0_reg;
      endcase
    end
    // Decoded from the next select so the flags are flip-flops in step with it
    ck19_next  = (c0_next[mscr_pkg::LSB_CKOUT +: 2] == mscr_pkg::CK_LCD_SEGMENT_19);
    ckfir_next = (c0_next[mscr_pkg::LSB_CKOUT +: 2] == mscr_pkg::CK_FILTER);
  end
  // ==========================================================================
  // Read paths; status bits come live, unstored positions return zero
  always_comb
  begin
    srd_next = 8'h00;
    if (i_sfr_rd)
    begin
      case (i_sfr_addr)
        mscr_pkg::SFR_PORT0_DATA:  srd_next = ((p0_reg & p0d_reg) | (pins_s[7:0] & ~p0d_reg)) & mscr_pkg::MASK_PORT0;
        mscr_pkg::SFR_PORT0_DIR:   srd_next = p0d_reg;
        mscr_pkg::SFR_PORT1_DATA:  srd_next = ((p1_reg & p1d_reg) | (pins_s[15:8] & ~p1d_reg)) & mscr_pkg::MASK_PORT1;
        mscr_pkg::SFR_PORT1_DIR:   srd_next = p1d_reg;
        mscr_pkg::SFR_PORT2_DATA:  srd_next = ((p2_reg & p2d_reg) | (pins_s[23:16] & ~p2d_reg)) & MASK_P2;
        mscr_pkg::SFR_PORT2_DIR:   srd_next = p2d_reg;
        mscr_pkg::SFR_FLASH_ERASE: srd_next = er_reg;
        mscr_pkg::SFR_EE_DATA:     srd_next = eed_reg;
        mscr_pkg::SFR_EE_CTRL:     srd_next = eec_reg;
        mscr_pkg::SFR_FLASH_CTRL:  srd_next = fc_reg;
        mscr_pkg::SFR_FLASH_PAGE:  srd_next = fp_reg;
        mscr_pkg::SFR_INT_FLAGS:   srd_next = if_reg;
        mscr_pkg::SFR_INT_BITS:    srd_next = {1'b0, i_int_bits};
        default:                   srd_next = 8'h00;
      endcase
    end
  end
  always_comb
  begin
    xrd_next = 8'h00;
    if (i_xa_rd)
    begin
      case (i_xa_addr)
        mscr_pkg::XA_ENGINE0: xrd_next = e0_reg;
        mscr_pkg::XA_ENGINE2: xrd_next = e2_reg;
        mscr_pkg::XA_COMP:    xrd_next = {7'h00, comp_s};
        mscr_pkg::XA_CONFIG0: xrd_next = c0_reg;
        mscr_pkg::XA_CONFIG1: xrd_next = c1_reg;
        mscr_pkg::XA_LCDX:    xrd_next = lx_reg;
        mscr_pkg::XA_ENGINE3: xrd_next = e3_reg;
        default:              xrd_next = 8'h00;
      endcase
    end
  end
  // ==========================================================================
  // Registers; all control state has a defined reset value
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      p0_reg <= 8'h00; p0d_reg <= 8'h00; p1_reg <= 8'h00; p1d_reg <= 8'h00;
      p2_reg <= 8'h00; p2d_reg <= 8'h00; er_reg <= 8'h00; eed_reg <= 8'h00;
      eec_reg <= 8'h00; fc_reg <= 8'h00; fp_reg <= 8'h00; if_reg <= 8'h00;
      e0_reg <= 8'h00; e2_reg <= 8'h00; c0_reg <= 8'h00;
      c1_reg <= 8'h00;
      lx_reg <= 8'h00;
      e3_reg <= {3'h0, mscr_pkg::LOC_RESET};
      srd_reg <= 8'h00; xrd_reg <= 8'h00;
      ck19_reg <= 1'b1;
      ckfir_reg <= 1'b0;
    end
    else
    begin
      p0_reg <= p0_next; p0d_reg <= p0d_next; p1_reg <= p1_next; p1d_reg <= p1d_next;
      p2_reg <= p2_next; p2d_reg <= p2d_next; er_reg <= er_next; eed_reg <= eed_next;
      eec_reg <= eec_next; fc_reg <= fc_next; fp_reg <= fp_next; if_reg <= if_next;
      e0_reg <= e0_next; e2_reg <= e2_next; c0_reg <= c0_next; c1_reg <= c1_next;
      lx_reg <= lx_next; e3_reg <= e3_next; srd_reg <= srd_next; xrd_reg <= xrd_next;
      ck19_reg <= ck19_next;
      ckfir_reg <= ckfir_next;
    end
  end
  // ==========================================================================
  // Chop control
  mscr_chop u_chop (
    .i_clk     (i_clk),
    .i_resetn  (i_resetn),
    .i_sync    (i_mux_sync),
    .i_acc_end (i_acc_end),
    .i_mode    (e2_reg[mscr_pkg::LSB_CHOP +: 2]),
    .o_chop    (o_chop)
  );
  // ==========================================================================
  // Outputs, all straight from flip-flops
  assign o_sfr_rdata = srd_reg;
  assign o_xa_rdata  = xrd_reg;
  // One means drive; every port pin counts as general-purpose here
  assign o_p0_out = p0_reg;
  assign o_p1_out = p1_reg;
  assign o_p2_out = p2_reg;
  assign o_p0_oe  = p0d_reg;
  assign o_p1_oe  = p1d_reg;
  assign o_p2_oe  = p2d_reg;
  logic unused_sel;
  assign unused_sel = ^i_gpio_sel;
  assign o_conv_enable   = c1_reg[mscr_pkg::BIT_CONV_EN];
  assign o_conv_bias_on  = c1_reg[mscr_pkg::BIT_CONV_EN];
  assign o_engine_enable = e0_reg[mscr_pkg::BIT_ENGINE_EN];
  // Start address is location times 1024, a plain shift
  assign o_engine_start  = {e3_reg[mscr_pkg::LOC_W-1:0], {mscr_pkg::LOC_SHIFT{1'b0}}};
  assign o_batt_load     = lx_reg[mscr_pkg::BIT_BATT];
  assign o_batt_to_conv  = lx_reg[mscr_pkg::BIT_BATT];
  assign o_test_clock_out_select = c0_reg[mscr_pkg::LSB_CKOUT +: 2];
  assign o_test_clk_is_lcd_segment_19  = ck19_reg;
  assign o_test_clk_is_filter = ckfir_reg;
  assign o_flash_erase = er_reg;
  assign o_flash_ctrl  = fc_reg;
  assign o_flash_page  = fp_reg;
  assign o_eeprom_data = eed_reg;
  assign o_eeprom_ctrl = eec_reg;
  // ==========================================================================
  // Checks
  property p_unused_zero;
    @(posedge i_clk) disable iff (!i_resetn)
    (i_sfr_rd && i_sfr_addr == 8'hb2) |=> (o_sfr_rdata[7:2] == 6'h00);
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bits read nonzero");
  property p_wo_zero;
    @(posedge i_clk) disable iff (!i_resetn)
    (i_xa_rd && i_xa_addr == 16'h2001) |=> (o_xa_rdata == 8'h00);
  endproperty
  a_wo_zero: assert property (p_wo_zero) else $error("unmapped read nonzero");
  property p_wr_visible;
    @(posedge i_clk) disable iff (!i_resetn)
    (i_xa_wr && i_xa_addr == 16'h20a8) ##1 (i_xa_rd && i_xa_addr == 16'h20a8 && !i_xa_wr)
      |=> (o_xa_rdata == ($past(i_xa_wdata, 2) & 8'h1f));
  endproperty
  a_wr_visible: assert property (p_wr_visible) else $error("write not visible");
  property p_start_addr;
    @(posedge i_clk) disable iff (!i_resetn)
    (o_engine_start == 15'(e3_reg[4:0]) * 15'd1024);
  endproperty
  a_start_addr: assert property (p_start_addr) else $error("engine start wrong");
  property p_flag_set_wins;
    @(posedge i_clk) disable iff (!i_resetn)
    (i_int_set != 8'h00) |=> ((o_sfr_rdata | if_reg) & $past(i_int_set)) == $past(i_int_set);
  endproperty
  a_flag_set_wins: assert property (p_flag_set_wins) else $error("flag set lost");
  property p_bias;
    @(posedge i_clk) disable iff (!i_resetn)
    !o_conv_enable |-> !o_conv_bias_on;
  endproperty
  a_bias: assert property (p_bias) else $error("bias on while converter off");
  property p_batt;
    @(posedge i_clk) disable iff (!i_resetn)
    (i_xa_wr && i_xa_addr == 16'h2020 && i_xa_wdata[6]) |=> (o_batt_load && o_batt_to_conv);
  endproperty
  a_batt: assert property (p_batt) else $error("battery measure not applied");
  property p_p2_small;
    @(posedge i_clk) disable iff (!i_resetn)
    !LARGE_PKG |-> (o_p2_oe[5:3] == 3'h0);
  endproperty
  a_p2_small: assert property (p_p2_small) else $error("port 2 upper bits on small package");
  property p_comp;
    @(posedge i_clk) disable iff (!i_resetn)
    (i_xa_rd && i_xa_addr == 16'h2003) |=> (o_xa_rdata[0] == $past(comp_s) && o_xa_rdata[7:1] == 7'h00);
  endproperty
  a_comp: assert property (p_comp) else $error("comparator status wrong");
  c_engine_on: cover property (@(posedge i_clk) disable iff (!i_resetn) $rose(o_engine_enable));
  c_batt_on:   cover property (@(posedge i_clk) disable iff (!i_resetn) $rose(o_batt_load));
  c_chop_rev:  cover property (@(posedge i_clk) disable iff (!i_resetn) $rose(o_chop));
endmodule
`default_nettype wire

/* File: test/mscr_cpu_model.sv */
// Bus-master model of the on-chip processor driving the register bank
`timescale 1ns/1ns
`default_nettype none
module mscr_cpu_model (
  input  wire logic        i_clk,
  output logic      [7:0]  o_sfr_addr,
  output logic             o_sfr_wr,
  output logic             o_sfr_rd,
  output logic      [7:0]  o_sfr_wdata,
  output logic      [15:0] o_xa_addr,
  output logic             o_xa_wr,
  output logic             o_xa_rd,
  output logic      [7:0]  o_xa_wdata,
  input  wire logic [7:0]  i_sfr_rdata,
  input  wire logic [7:0]  i_xa_rdata
);
  // ==========================================================================
  // Idle bus
  initial
  begin
    {o_sfr_wr, o_sfr_rd, o_xa_wr, o_xa_rd} = 4'h0;
    {o_sfr_addr, o_sfr_wdata, o_xa_addr, o_xa_wdata} = 40'h0;
  end
  // ==========================================================================
  // One-cycle access; released lines show inverted values so stale data never matches
  task automatic access(input bit xa, input bit wr, input logic [15:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    @(negedge i_clk);
    {o_sfr_addr, o_xa_addr, o_sfr_wdata, o_xa_wdata} = {a[7:0], a, d, d};
    {o_sfr_wr, o_sfr_rd, o_xa_wr, o_xa_rd} = {!xa && wr, !xa && !wr, xa && wr, xa && !wr};
    @(negedge i_clk);
    q = xa ? i_xa_rdata : i_sfr_rdata;
    {o_sfr_wr, o_sfr_rd, o_xa_wr, o_xa_rd} = 4'h0;
    {o_sfr_addr, o_xa_addr, o_sfr_wdata, o_xa_wdata} = ~{a[7:0], a, d, d};
  endtask
  // Window write followed on the very next edge by a read of the same address
  task automatic wr_rd(input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge i_clk);
    {o_xa_addr, o_xa_wdata, o_xa_wr, o_xa_rd} = {a, d, 2'b10};
    @(negedge i_clk);
    {o_xa_wr, o_xa_rd} = 2'b01;
    @(negedge i_clk);
    q = i_xa_rdata;
    {o_xa_wr, o_xa_rd} = 2'b00;
    {o_xa_addr, o_xa_wdata} = ~{a, d};
  endtask
  // Read-modify-write keeps bits outside the mask untouched
  task automatic update(input bit xa, input logic [15:0] a, input logic [7:0] m, input logic [7:0] v);
    logic [7:0] q;
    access(xa, 1'b0, a, 8'h00, q);
    access(xa, 1'b1, a, (q & ~m) | (v & m), q);
  endtask
endmodule
`default_nettype wire

/* File: test/mscr_top_tb.sv */
// Self-checking testbench of the metering configuration register bank
`timescale 1ns/1ns
`default_nettype none
module mscr_top_tb;
  logic        clk, resetn, sfr_wr, sfr_rd, xa_wr, xa_rd, comp_pin, mux_sync, acc_end;
  logic        conv_en, bias_on, eng_en, batt_load, batt_conv, chop, ck_filter, ck_lcd_segment_19;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, xa_wdata, xa_rdata, int_set, p1_pin, p1_oe, p2_oe, p2_out;
  logic [15:0] xa_addr;
  logic [7:0]  rb, fl_er, fl_ct, fl_pg, ee_d, ee_c, p0_out, p0_oe, p1_out;
  logic [14:0] eng_start;
  logic [6:0]  int_bits;
  logic [1:0]  ck_sel;
  int          fails = 0;
  int          n_tests = 0;
  logic [7:0]  t_addr[12] = '{8'ha1, 8'h91, 8'ha2, 8'ha0, 8'h90, 8'h94, 8'h9e, 8'h9f, 8'hb2, 8'hb7, 8'he8, 8'h81};
  logic [7:0]  t_exp[12]  = '{8'h3b, 8'hcf, 8'hf6, 8'h3b, 8'hcf, 8'hff, 8'hff, 8'hff, 8'h03, 8'hfe, 8'hff, 8'h00};
  mscr_cpu_model i_cpu (.i_clk(clk), .o_sfr_addr(sfr_addr), .o_sfr_wr(sfr_wr), .o_sfr_rd(sfr_rd),
    .o_sfr_wdata(sfr_wdata), .o_xa_addr(xa_addr), .o_xa_wr(xa_wr), .o_xa_rd(xa_rd), .o_xa_wdata(xa_wdata),
    .i_sfr_rdata(sfr_rdata), .i_xa_rdata(xa_rdata));
  mscr_top i_dut (.i_clk(clk), .i_resetn(resetn), .i_sfr_addr(sfr_addr), .i_sfr_wr(sfr_wr), .i_sfr_rd(sfr_rd),
    .i_sfr_wdata(sfr_wdata), .o_sfr_rdata(sfr_rdata), .i_xa_addr(xa_addr), .i_xa_wr(xa_wr), .i_xa_rd(xa_rd),
    .i_xa_wdata(xa_wdata), .o_xa_rdata(xa_rdata), .i_int_set(int_set), .i_int_bits(int_bits),
    .i_comp_pin(comp_pin), .i_mux_sync(mux_sync), .i_acc_end(acc_end), .i_gpio_sel(8'h00), .i_p0_pin(8'h00),
    .i_p1_pin(p1_pin), .i_p2_pin(8'h00), .o_p0_out(p0_out), .o_p0_oe(p0_oe), .o_p1_out(p1_out), .o_p1_oe(p1_oe),
    .o_p2_out(p2_out), .o_p2_oe(p2_oe), .o_conv_enable(conv_en), .o_conv_bias_on(bias_on),
    .o_engine_enable(eng_en), .o_engine_start(eng_start), .o_batt_load(batt_load),
    .o_batt_to_conv(batt_conv), .o_chop(chop), .o_test_clock_out_select(ck_sel),
    .o_test_clk_is_filter(ck_filter), .o_test_clk_is_lcd_segment_19(ck_lcd_segment_19), .o_flash_erase(fl_er),
    .o_flash_ctrl(fl_ct), .o_flash_page(fl_pg), .o_eeprom_data(ee_d), .o_eeprom_ctrl(ee_c));
  // ==========================================================================
  // Tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input bit xa, input logic [15:0] a, input logic [7:0] d);
    logic [7:0] q;
    i_cpu.access(xa, 1'b1, a, d, q);
  endtask
  task automatic rd(input bit xa, input logic [15:0] a, input logic [7:0] e);
    logic [7:0] q;
    i_cpu.access(xa, 1'b0, a, 8'h00, q);
    chk({8'h00, q}, {8'h00, e});
  endtask
  // Sync and accumulation end are held together so the edge sees both
  task automatic sync_pulse(input logic acc, input logic e);
    @(negedge clk);
    {mux_sync, acc_end} = {1'b1, acc};
    @(negedge clk);
    {mux_sync, acc_end} = 2'b00;
    repeat (3) @(negedge clk);
    chk({15'h0, chop}, {15'h0, e});
  endtask
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ==========================================================================
  // Clock, watchdog and test sequence
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    #200000;
    fails++;
    complete_run();
  end
  initial
  begin
    {resetn, comp_pin, mux_sync, acc_end, int_set, int_bits, p1_pin} = 27'h0;
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    rd(1, 16'h20a8, 8'h1f);
    rd(1, 16'h2005, 8'h00);
    chk({1'b0, eng_start}, 16'h7c00);
    chk({14'h0, conv_en, bias_on}, 16'h0000);
    wr(1, 16'h20a8, 8'hff);
    rd(1, 16'h20a8, 8'h1f);
    i_cpu.wr_rd(16'h20a8, 8'h0a, rb);
    chk({8'h00, rb}, 16'h000a);
    wr(1, 16'h20a8, 8'h05);
    rd(1, 16'h20a8, 8'h05);
    chk({1'b0, eng_start}, 16'h1400);
    i_cpu.update(1, 16'h2000, 8'h10, 8'h10);
    rd(1, 16'h2000, 8'h10);
    wr(1, 16'h2005, 8'hff);
    rd(1, 16'h2005, 8'h08);
    wr(1, 16'h2020, 8'hff);
    rd(1, 16'h2020, 8'h40);
    chk({11'h0, eng_en, conv_en, bias_on, batt_load, batt_conv}, 16'h001f);
    for (int m = 0; m < 4; m++)
    begin
      wr(1, 16'h2004, 8'(m << 4));
      rd(1, 16'h2004, 8'(m << 4));
      chk({12'h0, ck_sel, ck_filter, ck_lcd_segment_19}, {12'h0, 2'(m), m == 1, m == 0});
    end
    comp_pin = 1'b1;
    wr(1, 16'h2003, 8'h00);
    rd(1, 16'h2003, 8'h01);
    for (int i = 0; i < 12; i++)
    begin
      wr(0, {8'h00, t_addr[i]}, 8'hff);
      rd(0, {8'h00, t_addr[i]}, t_exp[i]);
    end
    chk({p2_out, p2_oe}, 16'h3b3b);
    chk({fl_er, ee_d}, 16'hffff);
    chk({fl_ct, fl_pg}, 16'h03fe);
    chk({ee_c, p1_out}, 16'hffcf);
    wr(0, 16'h0080, 8'hff);
    chk({p0_out, p0_oe}, 16'hf7f6);
    rd(0, 16'h0080, 8'hf6);
    p1_pin = 8'ha5;
    wr(0, 16'h0091, 8'h00);
    rd(0, 16'h0090, 8'h85);
    chk({8'h00, p1_oe}, 16'h0000);
    wr(0, 16'h00e8, 8'h00);
    int_set = 8'h81;
    int_bits = 7'h55;
    @(negedge clk);
    int_set = 8'h00;
    rd(0, 16'h00e8, 8'h81);
    rd(0, 16'h00f8, 8'h55);
    wr(1, 16'h2002, 8'h10);
    sync_pulse(1'b0, 1'b0);
    wr(1, 16'h2002, 8'h20);
    sync_pulse(1'b0, 1'b1);
    wr(1, 16'h2002, 8'h30);
    sync_pulse(1'b0, 1'b0);
    wr(1, 16'h2002, 8'h00);
    sync_pulse(1'b1, 1'b0);
    sync_pulse(1'b0, 1'b1);
    @(negedge clk);
    resetn = 1'b0;
    @(negedge clk);
    resetn = 1'b1;
    rd(1, 16'h20a8, 8'h1f);
    rd(0, 16'h00e8, 8'h00);
    chk({13'h0, chop, conv_en, ck_lcd_segment_19}, 16'h0001);
    complete_run();
  end
endmodule
`default_nettype wire
